// File: pwm_dt_pkg.sv
// Package of constants for the dead-time, sync and blanking block.
package pwm_dt_pkg;

    // ****************************************************************
    // Register map and field positions
    // ****************************************************************
    localparam logic [7:0] TBCTRL_OFS   = 8'h00;
    localparam logic [7:0] GENCTRL_OFS  = 8'h04;
    localparam logic [7:0] BLANK_OFS    = 8'h08;
    localparam logic [7:0] DUTY_OFS     = 8'h0c;
    localparam logic [7:0] DEADT_OFS    = 8'h10;
    localparam logic [7:0] ROUTE_OFS    = 8'h14;
    localparam logic [7:0] STATUS_OFS   = 8'h18;
    localparam logic [7:0] PERIOD_OFS   = 8'h1c;

    localparam int TB_ENABLE_BIT   = 15;
    localparam int SYNC_SRC_LSB    = 4;
    localparam int POSTSCALE_LSB   = 0;
    localparam int DTC_LSB         = 6;
    localparam int POL_BIT         = 5;
    localparam int TBSEL_BIT       = 3;
    localparam int CAM_BIT         = 2;
    localparam int EXTERNAL_PERIOD_RESET_BIT       = 1;
    localparam int IUE_BIT         = 0;
    localparam int ITB_BIT         = 9;
    localparam int CURRENT_LIMIT_MODE_BIT       = 8;

    localparam logic [2:0] SYNC_PIN      = 3'b000;
    localparam logic [2:0] SYNC_TRIG_A   = 3'b010;
    localparam logic [2:0] SYNC_TRIG_B   = 3'b011;

    localparam logic [1:0] DT_POSITIVE   = 2'b00;
    localparam logic [1:0] DT_NEGATIVE   = 2'b01;
    localparam logic [1:0] DT_OFF        = 2'b10;
    localparam logic [1:0] DT_COMP       = 2'b11;

    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam logic [15:0] BLANK_MASK   = 16'h0fff;
    localparam logic [15:0] GEN_MASK     = 16'h03ef;
    localparam logic [15:0] TB_MASK      = 16'h807f;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage

// File: pwm_dt_if.sv
// Interface carrying settings and edge events to the output stage.
`timescale 1ns/10ps
`default_nettype none
interface pwm_dt_if;
    logic [1:0]  dt_mode;
    logic        pol;
    logic        comp_in;
    logic [15:0] dead;
    logic        raw_pwm;
    logic        out_hi;
    logic        out_lo;
    modport ctrl  (output dt_mode, pol, comp_in, dead, raw_pwm,
                   input out_hi, out_lo);
    modport stage (input dt_mode, pol, comp_in, dead, raw_pwm,
                   output out_hi, out_lo);
endinterface
`default_nettype wire

// File: pwm_dt_stage.sv
// Dead-time output stage for one complementary high and low pair.
`timescale 1ns/10ps
`default_nettype none
module pwm_dt_stage
    import pwm_dt_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    pwm_dt_if.stage     port
);
    typedef struct packed {
        logic        prev;
        logic [16:0] cnt;
        logic        hi;
        logic        lo;
    } st_type;
    st_type s_q;
    st_type s_d;
    logic [16:0] gap;
    logic        eff_pol;

    // Gap length for the edge that just occurred; the compensated side
    // gets the doubled gap and the other none, shortening one output.
    always_comb begin
        eff_pol = (port.dt_mode == DT_COMP) ? port.pol : 1'b0;
        gap = {1'b0, port.dead};
        if (port.dt_mode == DT_OFF) begin
            gap = 17'h00000;
        end else if (port.dt_mode == DT_COMP) begin
            // Shortened output is high when polarity matches the input.
            // A gap on an edge delays the output turning on at that edge.
            if ((port.comp_in ^ eff_pol) != port.raw_pwm) begin
                gap = {port.dead, 1'b0};
            end else begin
                gap = 17'h00000;
            end
        end
    end

    // Outputs follow the raw edge after the gap; negative mode overlaps.
    always_comb begin
        s_d = s_q;
        s_d.prev = port.raw_pwm;
        if (s_q.prev != port.raw_pwm) begin
            s_d.cnt = gap;
        end else if (s_q.cnt != 17'h00000) begin
            s_d.cnt = s_q.cnt - 17'h00001;
        end
        unique case (port.dt_mode)
            DT_NEGATIVE: begin
                s_d.hi = port.raw_pwm | (s_d.cnt != 17'h00000);
                s_d.lo = ~port.raw_pwm | (s_d.cnt != 17'h00000);
            end
            default: begin
                s_d.hi = port.raw_pwm & (s_d.cnt == 17'h00000);
                s_d.lo = ~port.raw_pwm & (s_d.cnt == 17'h00000);
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign port.out_hi = s_q.hi;
    assign port.out_lo = s_q.lo;

    property p_no_overlap;
        @(posedge i_clk) disable iff (i_rst)
        (port.dt_mode != DT_NEGATIVE) |-> !(s_q.hi && s_q.lo);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("High and low outputs overlap outside negative mode.");
endmodule
`default_nettype wire

// File: pwm_dt_top.sv
// Generator with sync select, postscaler, blanking and register slave.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pwm_dt_top
    import pwm_dt_pkg::*;
#(
    parameter int SEL_W = 7
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RST,
    input  wire logic [7:0]        I_AWADDR,
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    output logic [1:0]             O_BRESP,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    input  wire logic [7:0]        I_ARADDR,
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    input  wire logic [127:0]      I_REMAP_PINS,
    input  wire logic              I_TRIG_GEN_A,
    input  wire logic              I_TRIG_GEN_B,
    input  wire logic              I_SECONDARY_TICK,
    input  wire logic              I_SECONDARY_PRESENT,
    input  wire logic              I_CURRENT_LIMIT,
    input  wire logic              I_FAULT,
    output logic                   O_HIGH_SIDE,
    output logic                   O_LOW_SIDE,
    output logic                   O_SPECIAL_EVENT,
    output logic                   O_LIMIT_BLANKED,
    output logic                   O_FAULT_BLANKED
);
    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] tb_ctrl;
        logic [15:0] gen_ctrl;
        logic [15:0] blank;
        logic [15:0] duty_buf;
        logic [15:0] dead_buf;
        logic [15:0] duty_act;
        logic [15:0] dead_act;
        logic [15:0] period;
        logic [15:0] route;
        logic [15:0] tb_cnt;
        logic        up;
        logic [3:0]  ps_cnt;
        logic        sev;
        logic [11:0] blank_cnt;
        logic        prev_hi;
        logic        sync_seen;
    } st_type;
    st_type s_q;
    st_type s_d;

    pwm_dt_if dt_bus ();

    // Pick one remappable pin; code zero reads as ground.
    function automatic logic pick_pin(input logic [127:0] pins,
                                      input logic [SEL_W-1:0] sel);
        pick_pin = (sel == '0) ? 1'b0 : pins[sel];
    endfunction

    logic        sync_in;
    logic        comp_in;
    logic        tb_on;
    logic        independent_time_base;
    logic        tick;
    logic        boundary;
    logic        match;
    logic        ext_reset;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] wmask;
    logic [31:0] rd_val;
    logic [1:0]  rd_resp;
    logic [15:0] wval16;

    // ****************************************************************
    // Input routing and time base
    // ****************************************************************
    // Sync source selection; reserved codes give no sync at all.
    always_comb begin
        unique case (s_q.tb_ctrl[SYNC_SRC_LSB +: 3])
            SYNC_PIN:    sync_in = pick_pin(I_REMAP_PINS,
                                            s_q.route[SEL_W-1:0]);
            SYNC_TRIG_A: sync_in = I_TRIG_GEN_A;
            SYNC_TRIG_B: sync_in = I_TRIG_GEN_B;
            default:     sync_in = 1'b0;
        endcase
    end

    assign comp_in = pick_pin(I_REMAP_PINS, s_q.route[8 +: SEL_W]);
    assign tb_on   = s_q.tb_ctrl[TB_ENABLE_BIT];
    assign independent_time_base     = s_q.gen_ctrl[ITB_BIT];
    // Secondary base only when one exists; otherwise primary clocking.
    assign tick = (s_q.gen_ctrl[TBSEL_BIT] && I_SECONDARY_PRESENT) ?
                  I_SECONDARY_TICK : 1'b1;
    // Limit input restarts the period only in independent mode.
    assign ext_reset = s_q.gen_ctrl[EXTERNAL_PERIOD_RESET_BIT] && independent_time_base &&
                       !s_q.gen_ctrl[CURRENT_LIMIT_MODE_BIT] && I_CURRENT_LIMIT;
    // Center alignment is ignored when the base is shared.
    assign boundary = tb_on && tick && (s_q.gen_ctrl[CAM_BIT] && independent_time_base ?
                      (!s_q.up && s_q.tb_cnt == 16'h0000) :
                      (s_q.tb_cnt >= s_q.period));
    assign match = boundary || (tb_on && sync_in) || (tb_on && ext_reset);

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    assign O_AWREADY = !s_q.aw_full;
    assign O_WREADY  = !s_q.w_full;
    assign O_ARREADY = !s_q.rvalid;
    assign wr_go = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    assign rd_go = I_ARVALID && !s_q.rvalid;
    assign wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
                    {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
    assign wval16 = s_q.w_data[15:0];

    // Read decode; unmapped addresses answer with a slave error.
    always_comb begin
        rd_val  = 32'h00000000;
        rd_resp = RESP_OKAY;
        unique case (I_ARADDR)
            TBCTRL_OFS:  rd_val = {16'h0000, s_q.tb_ctrl};
            GENCTRL_OFS: rd_val = {16'h0000, s_q.gen_ctrl};
            BLANK_OFS:   rd_val = {16'h0000, s_q.blank & BLANK_MASK};
            DUTY_OFS:    rd_val = {16'h0000, s_q.duty_buf};
            DEADT_OFS:   rd_val = {16'h0000, s_q.dead_buf};
            ROUTE_OFS:   rd_val = {16'h0000, s_q.route};
            STATUS_OFS:  rd_val = {s_q.tb_cnt, 12'h000, s_q.ps_cnt};
            PERIOD_OFS:  rd_val = {16'h0000, s_q.period};
            default:     rd_resp = RESP_SLVERR;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.sev = 1'b0;
        if (I_AWVALID && !s_q.aw_full) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = I_AWADDR;
        end
        if (I_WVALID && !s_q.w_full) begin
            s_d.w_full = 1'b1;
            s_d.w_data = I_WDATA;
            s_d.w_strb = I_WSTRB;
        end
        if (s_q.bvalid && I_BREADY) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && I_RREADY) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_val;
            s_d.rresp  = rd_resp;
        end
        // Time base: edge mode counts up, center mode counts up and down.
        if (!tb_on) begin
            s_d.tb_cnt = 16'h0000;
            s_d.up     = 1'b1;
        end else if (sync_in || ext_reset) begin
            s_d.tb_cnt = 16'h0000;
            s_d.up     = 1'b1;
        end else if (tick) begin
            if (s_q.gen_ctrl[CAM_BIT] && independent_time_base) begin
                if (s_q.up && s_q.tb_cnt >= s_q.period) begin
                    s_d.up = 1'b0;
                    s_d.tb_cnt = s_q.tb_cnt - 16'h0001;
                end else if (!s_q.up && s_q.tb_cnt == 16'h0000) begin
                    s_d.up = 1'b1;
                    s_d.tb_cnt = 16'h0001;
                end else begin
                    s_d.tb_cnt = s_q.up ? s_q.tb_cnt + 16'h0001 :
                                          s_q.tb_cnt - 16'h0001;
                end
            end else begin
                s_d.tb_cnt = boundary ? 16'h0000 : s_q.tb_cnt + 16'h0001;
            end
        end
        // Postscaler fires on match N+1 then restarts.
        if (!tb_on) begin
            s_d.ps_cnt = 4'h0;
        end else if (match) begin
            if (s_q.ps_cnt == s_q.tb_ctrl[POSTSCALE_LSB +: 4]) begin
                s_d.ps_cnt = 4'h0;
                s_d.sev    = 1'b1;
            end else begin
                s_d.ps_cnt = s_q.ps_cnt + 4'h1;
            end
        end
        // Buffered values reach the active copy at a match, or every cycle when IUE_BIT is set.
        if (s_q.gen_ctrl[IUE_BIT] || match) begin
            s_d.duty_act = s_q.duty_buf;
            s_d.dead_act = s_q.dead_buf;
        end
        // Blanking window opens on each rising edge of the raw PWM signal.
        s_d.prev_hi = dt_bus.raw_pwm;
        if (dt_bus.raw_pwm && !s_q.prev_hi) begin
            s_d.blank_cnt = s_q.blank[11:0];
        end else if (s_q.blank_cnt != 12'h000) begin
            s_d.blank_cnt = s_q.blank_cnt - 12'h001;
        end
        s_d.sync_seen = sync_in;
        if (wr_go) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            unique case (s_q.aw_addr)
                TBCTRL_OFS: begin
                    s_d.tb_ctrl = (s_q.tb_ctrl & ~wmask[15:0]) |
                                  (wval16 & wmask[15:0] & TB_MASK);
                    s_d.ps_cnt  = 4'h0;
                end
                GENCTRL_OFS: s_d.gen_ctrl = (s_q.gen_ctrl & ~wmask[15:0]) |
                                            (wval16 & wmask[15:0] & GEN_MASK);
                BLANK_OFS:   s_d.blank = (s_q.blank & ~wmask[15:0]) |
                                         (wval16 & wmask[15:0] & BLANK_MASK);
                DUTY_OFS:    s_d.duty_buf = (s_q.duty_buf & ~wmask[15:0]) |
                                            (wval16 & wmask[15:0]);
                DEADT_OFS:   s_d.dead_buf = (s_q.dead_buf & ~wmask[15:0]) |
                                            (wval16 & wmask[15:0]);
                ROUTE_OFS:   s_d.route = (s_q.route & ~wmask[15:0]) |
                                         (wval16 & wmask[15:0]);
                PERIOD_OFS:  s_d.period = (s_q.period & ~wmask[15:0]) |
                                          (wval16 & wmask[15:0]);
                STATUS_OFS:  s_d.bresp = RESP_OKAY;
                default:     s_d.bresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Output stage and ports
    // ****************************************************************
    assign dt_bus.dt_mode = s_q.gen_ctrl[DTC_LSB +: 2];
    assign dt_bus.pol     = s_q.gen_ctrl[POL_BIT];
    assign dt_bus.comp_in = comp_in;
    assign dt_bus.dead    = s_q.dead_act;
    assign dt_bus.raw_pwm = tb_on && (s_q.tb_cnt < s_q.duty_act);

    pwm_dt_stage u_stage (
        .i_clk (I_CLK),
        .i_rst (I_RST),
        .port  (dt_bus)
    );

    assign O_HIGH_SIDE     = dt_bus.out_hi;
    assign O_LOW_SIDE      = dt_bus.out_lo;
    assign O_SPECIAL_EVENT = s_q.sev;
    // Inputs are masked while the blanking window runs.
    assign O_LIMIT_BLANKED = I_CURRENT_LIMIT && (s_q.blank_cnt == 12'h000);
    assign O_FAULT_BLANKED = I_FAULT && (s_q.blank_cnt == 12'h000);
    assign O_BVALID = s_q.bvalid;
    assign O_BRESP  = s_q.bresp;
    assign O_RVALID = s_q.rvalid;
    assign O_RDATA  = s_q.rdata;
    assign O_RRESP  = s_q.rresp;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_sev_cause;
        @(posedge I_CLK) disable iff (I_RST)
        O_SPECIAL_EVENT |-> $past(match) && $past(tb_on);
    endproperty
    a_sev_cause: assert property (p_sev_cause)
        else $error("Special event without a compare match.");

    property p_ps_reset;
        @(posedge I_CLK) disable iff (I_RST)
        !tb_on |=> s_q.ps_cnt == 4'h0;
    endproperty
    a_ps_reset: assert property (p_ps_reset)
        else $error("Postscaler count kept while base disabled.");

    property p_blank_zero;
        @(posedge I_CLK) disable iff (I_RST)
        s_q.blank[15:12] == 4'h0;
    endproperty
    a_blank_zero: assert property (p_blank_zero)
        else $error("Blanking upper bits became nonzero.");

    property p_buffered;
        @(posedge I_CLK) disable iff (I_RST)
        (!s_q.gen_ctrl[IUE_BIT] && !match) |=> $stable(s_q.duty_act);
    endproperty
    a_buffered: assert property (p_buffered)
        else $error("Active duty changed away from a boundary.");

    property p_reserved_sync;
        @(posedge I_CLK) disable iff (I_RST)
        (s_q.tb_ctrl[SYNC_SRC_LSB +: 3] == 3'b001) |-> !sync_in;
    endproperty
    a_reserved_sync: assert property (p_reserved_sync)
        else $error("Reserved sync code produced a sync.");

    property p_external_period_reset;
        @(posedge I_CLK) disable iff (I_RST)
        (!independent_time_base || !s_q.gen_ctrl[EXTERNAL_PERIOD_RESET_BIT]) |-> !ext_reset;
    endproperty
    a_external_period_reset: assert property (p_external_period_reset)
        else $error("Limit input reset a shared time base.");

    property p_blank_hold;
        @(posedge I_CLK) disable iff (I_RST)
        (s_q.blank_cnt != 12'h000) |-> !O_FAULT_BLANKED;
    endproperty
    a_blank_hold: assert property (p_blank_hold)
        else $error("Fault passed during blanking window.");

    property p_route_gnd;
        @(posedge I_CLK) disable iff (I_RST)
        (s_q.route[8 +: SEL_W] == '0) |-> !comp_in;
    endproperty
    a_route_gnd: assert property (p_route_gnd)
        else $error("Selector zero did not tie input low.");
endmodule
`default_nettype wire

// File: pwm_far_model.sv
// Far-side model driving sync, trigger and limit inputs of the block.
`timescale 1ns/10ps
`default_nettype none
module pwm_far_model (
    input  wire logic         i_clk,
    input  wire logic         i_go,
    input  wire logic [1:0]   i_src,
    input  wire logic [6:0]   i_pin,
    input  wire logic         i_limit,
    output logic [127:0]      o_pins,
    output logic              o_trig_a,
    output logic              o_trig_b,
    output logic              o_limit
);
    // Pins idle low, so a stale pulse can never pass for a new one.
    initial begin
        o_pins = '0;
        o_trig_a = 1'b0;
        o_trig_b = 1'b0;
        o_limit = 1'b0;
    end
    // One-cycle sync pulse on the chosen source, pin or trigger output.
    always @(posedge i_clk) begin
        o_pins <= '0;
        o_trig_a <= i_go && (i_src == 2'd1);
        o_trig_b <= i_go && (i_src == 2'd2);
        o_limit <= i_limit;
        if (i_go && (i_src == 2'd0)) begin
            o_pins[i_pin] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: pwm_deadtime_sync_blanking_tb.sv
// Self-checking bench for the sync, postscaler and register block.
`timescale 1ns/10ps
`default_nettype none
module pwm_deadtime_sync_blanking_tb;
    import pwm_dt_pkg::*;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic         clk, rst, awv, wv, bready, arv, rready, go, lim;
    logic [7:0]   awaddr, araddr;
    logic [31:0]  wdata, rdata;
    logic [1:0]   src, bresp, rresp, rsp;
    logic [6:0]   pin;
    logic [127:0] pins;
    logic         awrdy, wrdy, bvalid, arrdy, rvalid, sev, lim_b, flt_b;
    logic         trg_a, trg_b, lim_s, hi, lo, sec_pres;
    int           n_mismatch, checks, cyc, n_evt, n_hi, n_lo, n_lb;
    pwm_far_model i_pwm_far_model (.i_clk(clk), .i_go(go), .i_src(src),
        .i_pin(pin), .i_limit(lim), .o_pins(pins), .o_trig_a(trg_a),
        .o_trig_b(trg_b), .o_limit(lim_s));
    pwm_dt_top i_pwm_dt_top (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr),
        .I_AWVALID(awv), .O_AWREADY(awrdy), .I_WDATA(wdata),
        .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
        .I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_REMAP_PINS(pins), .I_TRIG_GEN_A(trg_a), .I_TRIG_GEN_B(trg_b),
        .I_SECONDARY_TICK(1'b0), .I_SECONDARY_PRESENT(sec_pres),
        .I_CURRENT_LIMIT(lim_s), .I_FAULT(lim_s), .O_HIGH_SIDE(hi),
        .O_LOW_SIDE(lo), .O_SPECIAL_EVENT(sev), .O_LIMIT_BLANKED(lim_b),
        .O_FAULT_BLANKED(flt_b));
    // ****************************************************************
    // Clock, timeout and bus tasks
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counts special events and output cycles; a hang is cut short by the cycle ceiling.
    always @(posedge clk) begin
        cyc++;
        if (sev === 1'b1) n_evt++;
        if (hi === 1'b1) n_hi++;
        if (lo === 1'b1) n_lo++;
        if (lim_b === 1'b1) n_lb++;
        if (cyc == 6000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Answers are sampled mid-cycle, where they equal the edge value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = awv && awrdy === 1'b1;
            tw = wv && wrdy === 1'b1;
            tb = bvalid === 1'b1;
            rsp = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic ta, tb;
        tb = 1'b0;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = arv && arrdy === 1'b1;
            tb = rvalid === 1'b1;
            d = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tb) rready <= 1'b0;
        end
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values, masks, unmapped access and blanking pass-through.
    task automatic reg_case();
        logic [31:0] d;
        lim <= 1'b1;
        rd(BLANK_OFS, d);
        chk(d, 32'h0);
        repeat (3) @(posedge clk);
        chk({30'h0, lim_b, flt_b}, 32'h3);
        wr(BLANK_OFS, 32'hffff_ffff);
        rd(BLANK_OFS, d);
        chk(d, 32'h0fff);
        wr(GENCTRL_OFS, 32'h0000_ffff);
        rd(GENCTRL_OFS, d);
        chk(d, {16'h0, GEN_MASK});
        wr(GENCTRL_OFS, 32'h0);
        wr(8'h40, 32'h1);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        rd(8'h40, d);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        lim <= 1'b0;
    endtask
    // Fields change only with the base stopped; then pulses are counted.
    task automatic sync_case(input logic [2:0] code, input logic [1:0] s,
        input logic [6:0] sel, input logic [3:0] n, input int p,
        input int exp);
        wr(TBCTRL_OFS, {25'h0, code, n});
        wr(ROUTE_OFS, {25'h0, sel});
        wr(TBCTRL_OFS, {16'h0, 1'b1, 8'h0, code, n});
        n_evt = 0;
        src <= s;
        pin <= sel;
        repeat (p) begin
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            repeat (6) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        chk(n_evt, exp);
        wr(TBCTRL_OFS, 32'h0);
    endtask
    // Output and blanking cycles counted over four 20-cycle periods.
    // Counters are cleared and read off the edge to avoid a race.
    task automatic out_case(input logic [15:0] g, input int e_hi,
        input int e_lo, input int e_lb);
        wr(GENCTRL_OFS, {16'h0, g});
        wr(TBCTRL_OFS, 32'h0000_8000);
        repeat (60) @(posedge clk);
        @(negedge clk);
        {n_hi, n_lo, n_lb} = '0;
        repeat (80) @(posedge clk);
        @(negedge clk);
        chk(n_hi, e_hi);
        chk(n_lo, e_lo);
        chk(n_lb, e_lb);
        wr(TBCTRL_OFS, 32'h0);
    endtask
    initial begin
        {awv, wv, bready, arv, rready, go, lim, sec_pres} = '0;
        {awaddr, araddr, wdata, src, pin} = '0;
        {n_mismatch, checks, cyc, n_evt, n_hi, n_lo, n_lb} = '0;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reg_case();
        wr(PERIOD_OFS, 32'hffff);
        sync_case(SYNC_TRIG_A, 2'd1, 7'd0, 4'h3, 8, 2);
        sync_case(SYNC_TRIG_B, 2'd2, 7'd0, 4'h0, 4, 4);
        sync_case(SYNC_PIN, 2'd0, 7'd5, 4'hf, 16, 1);
        sync_case(SYNC_PIN, 2'd0, 7'd0, 4'h0, 4, 0);
        sync_case(3'b001, 2'd1, 7'd0, 4'h0, 4, 0);
        // Period 20 cycles, duty 10, dead time 3, blanking 5, limit on.
        // No interrupt status lives in this block to clear.
        lim <= 1'b1;
        sec_pres <= 1'b1;
        wr(PERIOD_OFS, 32'h13);
        wr(DUTY_OFS, 32'ha);
        wr(DEADT_OFS, 32'h3);
        wr(BLANK_OFS, 32'h5);
        out_case(16'h0000, 28, 28, 60);
        out_case(16'h0020, 28, 28, 60);
        out_case(16'h0004, 28, 28, 60);
        out_case(16'h00e0, 40, 16, 60);
        out_case(16'h00c0, 16, 40, 60);
        out_case(16'h0080, 40, 40, 60);
        out_case(16'h0202, 80, 0, 80);
        out_case(16'h0008, 80, 0, 80);
        out_case(16'h0040, 52, 52, 60);
        end_of_test();
    end
endmodule
`default_nettype wire
